//--- src/lpp_post.sv
`include "lpp_defs.svh"
`default_nettype none
module lpp_post (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pixValid,
    input wire logic [7:0] pixIndex,
    input wire logic [23:0] lutRgb,
    input wire logic [23:0] osdRgb,
    input wire logic [15:0] pixRow,
    input wire logic [15:0] pixCol,
    input wire logic vsyncPulse,
    output logic [7:0] lutAddr,
    output logic lutAddrValid,
    output logic [23:0] pixRgb,
    output logic pixRgbValid,
    output logic stnPixelOn
);

    lpp_pkg::lpp_state_t st_reg;
    lpp_pkg::lpp_state_t st_next;

    logic [31:0] rdData;
    logic [7:0] palByte;
    logic [23:0] vidRgb;
    logic [23:0] blendRgb;
    logic [23:0] mixRgb;
    logic inVid;
    logic inOsd;
    logic keyMatch;
    logic ditherBit;
    logic [1:0] selCode;

    // Weighted mix of one component, weight applies to video
    function automatic logic [7:0] blendComp(
        input logic [7:0] v,
        input logic [7:0] o,
        input logic [2:0] w
    );
        logic [11:0] sum;
        sum = {4'h0, v} * {9'h000, w}
            + {4'h0, o} * (12'h008 - {9'h000, w});
        return sum[10:3];
    endfunction

    // ************************************************
    // Next-state logic
    // ************************************************
    always_comb begin
        logic [3:0] g;
        logic [3:0] gm1;
        logic [15:0] pat;
        logic [6:0] fill;
        logic [23:0] keyDiff;
        g = pixIndex[3:0];
        gm1 = 4'h0;
        pat = 16'h0000;
        fill = st_reg.dummyColour[`LPP_GRAY_F];
        keyDiff = 24'h000000;
        st_next = st_reg;

        // ************************************************
        // AHB-Lite slave, zero wait states
        // ************************************************
        st_next.hreadyout = 1'b1;
        st_next.aValid = 1'b0;
        if (hsel && hready && htrans[`LPP_HTRANS_NONSEQ_B]
                && hsize == `LPP_HSIZE_WORD) begin
            st_next.aValid = 1'b1;
            st_next.aWrite = hwrite;
            st_next.aAddr = haddr;
        end
        if (st_reg.aValid && st_reg.aWrite) begin
            unique case (st_reg.aAddr)
                `LPP_ADDR_MODE:
                    st_next.modeCtrl = hwdata[`LPP_MODE_W-1:0];
                `LPP_ADDR_PAL0: st_next.palIdx[0] = hwdata;
                `LPP_ADDR_PAL1: st_next.palIdx[1] = hwdata;
                `LPP_ADDR_PAL2: st_next.palIdx[2] = hwdata;
                `LPP_ADDR_PAL3: st_next.palIdx[3] = hwdata;
                `LPP_ADDR_DITH0: st_next.dither[0] = hwdata;
                `LPP_ADDR_DITH1: st_next.dither[1] = hwdata;
                `LPP_ADDR_DITH2: st_next.dither[2] = hwdata;
                `LPP_ADDR_DITH3: st_next.dither[3] = hwdata;
                `LPP_ADDR_DITH4: st_next.dither[4] = hwdata;
                `LPP_ADDR_DITH5: st_next.dither[5] = hwdata;
                `LPP_ADDR_DITH6: st_next.dither[6] = hwdata;
                // Bit 31 is reserved and reads zero
                `LPP_ADDR_DUMMY:
                    st_next.dummyColour = {1'b0, hwdata[30:0]};
                `LPP_ADDR_VSTART: st_next.vidStart = hwdata;
                `LPP_ADDR_VEND: st_next.vidEnd = hwdata;
                `LPP_ADDR_OSTART: st_next.osdStart = hwdata;
                `LPP_ADDR_OEND: st_next.osdEnd = hwdata;
                `LPP_ADDR_MIX: st_next.mixCtrl = {8'h00,
                    hwdata[`LPP_BLINKCNT_F], 6'h00,
                    hwdata[`LPP_BLINKEN_B:`LPP_KEYEN_B], 1'b0,
                    hwdata[6:0]};
                `LPP_ADDR_KEYV: st_next.keyValue = {8'h00, hwdata[23:0]};
                `LPP_ADDR_KEYM: st_next.keyMask = {8'h00, hwdata[23:0]};
                default: ;
            endcase
        end

        // After the write, so back to back read sees it
        unique case (haddr)
            `LPP_ADDR_STATUS: rdData = {19'h00000, st_next.osdHidden,
                st_next.blinkCnt, st_next.frameCnt};
            `LPP_ADDR_MODE: rdData = {29'h00000000, st_next.modeCtrl};
            `LPP_ADDR_PAL0: rdData = st_next.palIdx[0];
            `LPP_ADDR_PAL1: rdData = st_next.palIdx[1];
            `LPP_ADDR_PAL2: rdData = st_next.palIdx[2];
            `LPP_ADDR_PAL3: rdData = st_next.palIdx[3];
            `LPP_ADDR_DITH0: rdData = st_next.dither[0];
            `LPP_ADDR_DITH1: rdData = st_next.dither[1];
            `LPP_ADDR_DITH2: rdData = st_next.dither[2];
            `LPP_ADDR_DITH3: rdData = st_next.dither[3];
            `LPP_ADDR_DITH4: rdData = st_next.dither[4];
            `LPP_ADDR_DITH5: rdData = st_next.dither[5];
            `LPP_ADDR_DITH6: rdData = st_next.dither[6];
            `LPP_ADDR_DUMMY: rdData = st_next.dummyColour;
            `LPP_ADDR_VSTART: rdData = st_next.vidStart;
            `LPP_ADDR_VEND: rdData = st_next.vidEnd;
            `LPP_ADDR_OSTART: rdData = st_next.osdStart;
            `LPP_ADDR_OEND: rdData = st_next.osdEnd;
            `LPP_ADDR_MIX: rdData = st_next.mixCtrl;
            `LPP_ADDR_KEYV: rdData = st_next.keyValue;
            `LPP_ADDR_KEYM: rdData = st_next.keyMask;
            default: rdData = `LPP_RST_WORD;
        endcase
        if (st_next.aValid && !hwrite) begin
            st_next.hrdata = rdData;
        end

        // ************************************************
        // Frame and blink timing
        // ************************************************
        if (vsyncPulse) begin
            st_next.frameCnt = st_reg.frameCnt + 4'h1;
        end
        if (!st_reg.mixCtrl[`LPP_BLINKEN_B]) begin
            st_next.blinkCnt = 8'h00;
            st_next.osdHidden = 1'b0;
        end else if (vsyncPulse) begin
            // Period 0 or 1 toggles every vertical sync
            if (st_reg.blinkCnt + 8'h01
                    >= st_reg.mixCtrl[`LPP_BLINKCNT_F]) begin
                st_next.blinkCnt = 8'h00;
                st_next.osdHidden = !st_reg.osdHidden;
            end else begin
                st_next.blinkCnt = st_reg.blinkCnt + 8'h01;
            end
        end

        // ************************************************
        // Lookup address and dither
        // ************************************************
        palByte = st_reg.palIdx[pixIndex[3:2]][pixIndex[1:0]*8 +: 8];
        if (g == `LPP_GRAY_MIN) begin
            ditherBit = 1'b0;
        end else if (g == `LPP_GRAY_MAX) begin
            ditherBit = 1'b1;
        end else begin
            gm1 = g - 4'h1;
            pat = gm1[0]
                ? st_reg.dither[gm1[3:1]][31:`LPP_DITH_HALF_W]
                : st_reg.dither[gm1[3:1]][`LPP_DITH_HALF_W-1:0];
            ditherBit = pat[st_reg.frameCnt];
        end

        // ************************************************
        // Colour source and windows
        // ************************************************
        // Raw 8bpp is read as 3-3-2 with low bits replenished
        if (st_reg.modeCtrl[`LPP_MODE_BPP8_B]
                && !st_reg.modeCtrl[`LPP_MODE_PALETTE_LOOKUP_ENABLE_B]) begin
            vidRgb = {pixIndex[7:5], fill[6:2], pixIndex[4:2],
                fill[6:2], pixIndex[1:0], fill[6:1]};
        end else begin
            vidRgb = lutRgb;
        end
        inVid = pixRow >= st_reg.vidStart[`LPP_ROW_F]
            && pixCol >= st_reg.vidStart[`LPP_COL_F]
            && pixRow <= st_reg.vidEnd[`LPP_ROW_F]
            && pixCol <= st_reg.vidEnd[`LPP_COL_F];
        inOsd = pixRow >= st_reg.osdStart[`LPP_ROW_F]
            && pixCol >= st_reg.osdStart[`LPP_COL_F]
            && pixRow <= st_reg.osdEnd[`LPP_ROW_F]
            && pixCol <= st_reg.osdEnd[`LPP_COL_F];
        keyDiff = (osdRgb ^ st_reg.keyValue[23:0])
            & ~st_reg.keyMask[23:0];
        keyMatch = st_reg.mixCtrl[`LPP_KEYEN_B]
            && keyDiff == 24'h000000;
        blendRgb = {
            blendComp(vidRgb[`LPP_RED_F], osdRgb[`LPP_RED_F],
                st_reg.mixCtrl[`LPP_WEIGHT_F]),
            blendComp(vidRgb[`LPP_GRN_F], osdRgb[`LPP_GRN_F],
                st_reg.mixCtrl[`LPP_WEIGHT_F]),
            blendComp(vidRgb[`LPP_BLU_F], osdRgb[`LPP_BLU_F],
                st_reg.mixCtrl[`LPP_WEIGHT_F])};
        selCode = keyMatch ? st_reg.mixCtrl[`LPP_SELMATCH_F]
            : st_reg.mixCtrl[`LPP_SELMISS_F];
        // Hidden blink phase drops the overlay entirely
        if (!inOsd || st_reg.osdHidden) begin
            mixRgb = vidRgb;
        end else begin
            unique case (selCode)
                `LPP_SEL_OSD: mixRgb = osdRgb;
                `LPP_SEL_BLEND: mixRgb = blendRgb;
                default: mixRgb = vidRgb;
            endcase
        end

        st_next.lutValid = pixValid;
        st_next.pixRgbValid = pixValid;
        if (pixValid) begin
            st_next.lutAddr = st_reg.modeCtrl[`LPP_MODE_BPP8_B]
                ? pixIndex : palByte;
            st_next.stnOn = ditherBit;
            st_next.pixRgb = inVid ? mixRgb
                : st_reg.dummyColour[23:0];
        end
    end

    // ************************************************
    // State register
    // ************************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.hreadyout <= 1'b1;
            st_reg.dither[0] <= `LPP_RST_DITH0;
            st_reg.dither[1] <= `LPP_RST_DITH1;
            st_reg.dither[2] <= `LPP_RST_DITH2;
            st_reg.dither[3] <= `LPP_RST_DITH3;
            st_reg.dither[4] <= `LPP_RST_DITH4;
            st_reg.dither[5] <= `LPP_RST_DITH5;
            st_reg.dither[6] <= `LPP_RST_DITH6;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hreadyout = st_reg.hreadyout;
    assign hresp = 1'b0;
    assign hrdata = st_reg.hrdata;
    assign lutAddr = st_reg.lutAddr;
    assign lutAddrValid = st_reg.lutValid;
    assign pixRgb = st_reg.pixRgb;
    assign pixRgbValid = st_reg.pixRgbValid;
    assign stnPixelOn = st_reg.stnOn;

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    lut_direct_a: assert property (
        pixValid && st_reg.modeCtrl[`LPP_MODE_BPP8_B]
        |=> lutAddr == $past(pixIndex) && lutAddrValid)
        else $error("8bpp lookup address differs from pixel");
    lut_palette_a: assert property (
        pixValid && !st_reg.modeCtrl[`LPP_MODE_BPP8_B]
        |=> lutAddr == $past(palByte))
        else $error("4bpp lookup address wrong palette byte");
    gray_ends_a: assert property (
        pixValid && pixIndex[3:0] == `LPP_GRAY_MIN |=> !stnPixelOn)
        else $error("gray zero lit");
    gray_full_a: assert property (
        pixValid && pixIndex[3:0] == `LPP_GRAY_MAX |=> stnPixelOn)
        else $error("gray fifteen dark");
    frame_step_a: assert property (
        vsyncPulse |=> st_reg.frameCnt == $past(st_reg.frameCnt) + 4'h1)
        else $error("frame counter did not advance");
    blink_off_a: assert property (
        !st_reg.mixCtrl[`LPP_BLINKEN_B] |=> !st_reg.osdHidden)
        else $error("overlay hidden while blink disabled");
    dummy_out_a: assert property (
        pixValid && !inVid
        |=> pixRgb == $past(st_reg.dummyColour[23:0]))
        else $error("dummy colour not shown outside video");
    osd_video_a: assert property (
        pixValid && inVid && !inOsd |=> pixRgb == $past(vidRgb))
        else $error("video not shown outside overlay");
    key_osd_a: assert property (
        pixValid && inVid && inOsd && !st_reg.osdHidden && keyMatch
        && st_reg.mixCtrl[`LPP_SELMATCH_F] == `LPP_SEL_OSD
        |=> pixRgb == $past(osdRgb))
        else $error("key match did not select overlay");
    blink_toggle_a: assert property (
        vsyncPulse && st_reg.mixCtrl[`LPP_BLINKEN_B]
        && st_reg.mixCtrl[`LPP_BLINKCNT_F] == 8'h01
        ##1 st_reg.mixCtrl[`LPP_BLINKEN_B]
        |-> st_reg.osdHidden != $past(st_reg.osdHidden, 1))
        else $error("blink phase did not toggle");
    bus_ready_a: assert property (
        hreadyout && !hresp)
        else $error("slave stalled or errored");

    // ************************************************
    // Mixing, frame and stream checks
    // ************************************************
    blend_weight_a: assert property (
        pixValid && inVid && inOsd && !st_reg.osdHidden
        && selCode == `LPP_SEL_BLEND
        && st_reg.mixCtrl[`LPP_WEIGHT_F] == 3'h0
        |=> pixRgb == $past(osdRgb))
        else $error("zero weight blend not pure overlay");

    miss_video_a: assert property (
        pixValid && inVid && inOsd && !st_reg.osdHidden && !keyMatch
        && st_reg.mixCtrl[`LPP_SELMISS_F] == `LPP_SEL_VIDEO
        |=> pixRgb == $past(vidRgb))
        else $error("key miss did not select video");

    key_off_a: assert property (
        pixValid && inVid && inOsd && !st_reg.osdHidden
        && !st_reg.mixCtrl[`LPP_KEYEN_B]
        && st_reg.mixCtrl[`LPP_SELMATCH_F] == `LPP_SEL_OSD
        && st_reg.mixCtrl[`LPP_SELMISS_F] == `LPP_SEL_VIDEO
        |=> pixRgb == $past(vidRgb))
        else $error("disabled key still matched");

    spare_code_a: assert property (
        pixValid && inVid && inOsd && !st_reg.osdHidden
        && selCode == `LPP_SEL_SPARE
        |=> pixRgb == $past(vidRgb))
        else $error("code three did not select video");

    hidden_video_a: assert property (
        pixValid && inVid && st_reg.osdHidden
        |=> pixRgb == $past(vidRgb))
        else $error("overlay shown while hidden");

    raw_fill_a: assert property (
        pixValid && inVid && !inOsd
        && st_reg.modeCtrl[`LPP_MODE_BPP8_B]
        && !st_reg.modeCtrl[`LPP_MODE_PALETTE_LOOKUP_ENABLE_B]
        |=> pixRgb[7:6] == $past(pixIndex[1:0])
        && pixRgb[5:0] == $past(st_reg.dummyColour[30:25]))
        else $error("raw pixel not replenished");

    frame_hold_a: assert property (
        !vsyncPulse |=> $stable(st_reg.frameCnt))
        else $error("frame counter moved without sync");

    stream_idle_a: assert property (
        !pixValid |=> !lutAddrValid && !pixRgbValid && $stable(lutAddr))
        else $error("lookup output moved without pixel");

endmodule // lpp_post
`default_nettype wire

//--- src/lpp_defs.svh
`ifndef LPP_DEFS_SVH
`define LPP_DEFS_SVH

// Register byte addresses
`define LPP_ADDR_STATUS 32'hfff08048
`define LPP_ADDR_MODE 32'hfff0804c
`define LPP_ADDR_PAL0 32'hfff08050
`define LPP_ADDR_PAL1 32'hfff08054
`define LPP_ADDR_PAL2 32'hfff08058
`define LPP_ADDR_PAL3 32'hfff0805c
`define LPP_ADDR_DITH0 32'hfff08070
`define LPP_ADDR_DITH1 32'hfff08074
`define LPP_ADDR_DITH2 32'hfff08078
`define LPP_ADDR_DITH3 32'hfff0807c
`define LPP_ADDR_DITH4 32'hfff08080
`define LPP_ADDR_DITH5 32'hfff08084
`define LPP_ADDR_DITH6 32'hfff08088
`define LPP_ADDR_DUMMY 32'hfff08090
`define LPP_ADDR_VSTART 32'hfff08094
`define LPP_ADDR_VEND 32'hfff08098
`define LPP_ADDR_OSTART 32'hfff0809c
`define LPP_ADDR_OEND 32'hfff080a0
`define LPP_ADDR_MIX 32'hfff080a4
`define LPP_ADDR_KEYV 32'hfff080a8
`define LPP_ADDR_KEYM 32'hfff080ac

// Reset values
`define LPP_RST_WORD 32'h00000000
`define LPP_RST_DITH0 32'h01010001
`define LPP_RST_DITH1 32'h11110841
`define LPP_RST_DITH2 32'h49492491
`define LPP_RST_DITH3 32'h555552a5
`define LPP_RST_DITH4 32'hb6b6b556
`define LPP_RST_DITH5 32'heeeedb6e
`define LPP_RST_DITH6 32'hfefeefbe

// Field positions
`define LPP_ROW_F 31:16
`define LPP_COL_F 15:0
`define LPP_GRAY_F 30:24
`define LPP_RED_F 23:16
`define LPP_GRN_F 15:8
`define LPP_BLU_F 7:0
`define LPP_BLINKCNT_F 23:16
`define LPP_BLINKEN_B 9
`define LPP_KEYEN_B 8
`define LPP_WEIGHT_F 6:4
`define LPP_SELMATCH_F 3:2
`define LPP_SELMISS_F 1:0
`define LPP_MODE_PALETTE_LOOKUP_ENABLE_B 0
`define LPP_MODE_BPP8_B 1
`define LPP_MODE_W 3
`define LPP_DITH_HALF_W 16

// Overlay source codes
`define LPP_SEL_VIDEO 2'h0
`define LPP_SEL_OSD 2'h1
`define LPP_SEL_BLEND 2'h2
`define LPP_SEL_SPARE 2'h3

// Bus and gray-level constants
`define LPP_HTRANS_NONSEQ_B 1
`define LPP_HSIZE_WORD 3'h2
`define LPP_GRAY_MAX 4'hf
`define LPP_GRAY_MIN 4'h0

`endif

//--- src/lpp_pkg.sv
`default_nettype none
package lpp_pkg;
    typedef struct packed {
        logic [31:0] dummyColour;
        logic [31:0] vidStart;
        logic [31:0] vidEnd;
        logic [31:0] osdStart;
        logic [31:0] osdEnd;
        logic [31:0] mixCtrl;
        logic [31:0] keyValue;
        logic [31:0] keyMask;
        logic [3:0][31:0] palIdx;
        logic [6:0][31:0] dither;
        logic [2:0] modeCtrl;
        logic aValid;
        logic aWrite;
        logic [31:0] aAddr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic [3:0] frameCnt;
        logic [7:0] blinkCnt;
        logic osdHidden;
        logic [7:0] lutAddr;
        logic lutValid;
        logic [23:0] pixRgb;
        logic pixRgbValid;
        logic stnOn;
    } lpp_state_t;
endpackage
`default_nettype wire

//--- dv/lpp_panel_model.sv
`default_nettype none
module lpp_panel_model (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [23:0] pixRgb,
    input wire logic pixRgbValid,
    input wire logic stnPixelOn,
    output logic [23:0] panelRgb,
    output logic panelOn,
    output int panelCount
);
    timeunit 1ns;
    timeprecision 1ps;
    // Latches strobed pixels only; a stale colour never passes as new
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            panelRgb <= 24'h000000;
            panelOn <= 1'b0;
            panelCount <= 0;
        end else if (pixRgbValid) begin
            panelRgb <= pixRgb;
            panelOn <= stnPixelOn;
            panelCount <= panelCount + 1;
        end
    end
endmodule // lpp_panel_model
`default_nettype wire

//--- dv/lpp_post_tb.sv
`include "lpp_defs.svh"
`default_nettype none
`define CHECK_EQ(got, exp) begin \
    testsRun++; \
    if ((got) !== (exp)) begin \
        numErrors++; \
        $display("[FAIL] %0t: got %h expected %h", $time, got, exp); \
    end \
end
module lpp_post_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] VC = 24'h804020;
    localparam logic [23:0] OC = 24'h10f008;
    logic ref_clk, nrst, hsel, hwrite, pixValid, vsyncPulse;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, lutAddrValid, pixRgbValid, stnPixelOn;
    logic [7:0] pixIndex, lutAddr;
    logic [23:0] lutRgb, osdRgb, pixRgb, panelRgb;
    logic [15:0] pixRow, pixCol;
    logic panelOn;
    int panelCount, numErrors, testsRun, pixSent;
    wire logic hready = hreadyout;

    lpp_post dut_u (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pixValid(pixValid),
        .pixIndex(pixIndex), .lutRgb(lutRgb), .osdRgb(osdRgb),
        .pixRow(pixRow), .pixCol(pixCol), .vsyncPulse(vsyncPulse),
        .lutAddr(lutAddr), .lutAddrValid(lutAddrValid), .pixRgb(pixRgb),
        .pixRgbValid(pixRgbValid), .stnPixelOn(stnPixelOn));
    lpp_panel_model panel_u (.ref_clk(ref_clk), .nrst(nrst),
        .pixRgb(pixRgb), .pixRgbValid(pixRgbValid),
        .stnPixelOn(stnPixelOn), .panelRgb(panelRgb), .panelOn(panelOn),
        .panelCount(panelCount));

    always #2 ref_clk = ~ref_clk;

    // ****************************************
    // Bus and stream helpers
    // ****************************************
    task automatic waitRdy;
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask
    task automatic busXfer(input logic [31:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        r = hrdata;
        hsel <= 1'b0;
    endtask
    task automatic busWr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        busXfer(a, 1'b1, d, r);
    endtask
    task automatic busRd(input logic [31:0] a, output logic [31:0] r);
        busXfer(a, 1'b0, 32'h00000000, r);
    endtask
    task automatic pix(input logic [7:0] idx, input logic [23:0] v,
        input logic [23:0] o, input logic [15:0] row, input logic [15:0] col);
        @(posedge ref_clk);
        pixValid <= 1'b1;
        pixSent++;
        pixIndex <= idx;
        lutRgb <= v;
        osdRgb <= o;
        pixRow <= row;
        pixCol <= col;
        @(posedge ref_clk);
        pixValid <= 1'b0;
        #1;
        `CHECK_EQ({lutAddrValid, pixRgbValid}, 2'b11)
        @(posedge ref_clk);
        #1;
    endtask
    task automatic vsync;
        @(posedge ref_clk);
        vsyncPulse <= 1'b1;
        @(posedge ref_clk);
        vsyncPulse <= 1'b0;
    endtask
    task automatic inWin(input logic [23:0] e);
        pix(8'h00, VC, OC, 16'd15, 16'd15);
        `CHECK_EQ(panelRgb, e)
    endtask
    function automatic logic [23:0] mixExp(input logic [1:0] c,
        input logic [2:0] w);
        logic [23:0] b;
        for (int k = 0; k < 3; k++) begin
            b[8*k+:8] = 8'((11'(VC[8*k+:8]) * w
                + 11'(OC[8*k+:8]) * (4'd8 - w)) >> 3);
        end
        case (c)
            2'h1: return OC;
            2'h2: return b;
            default: return VC;
        endcase
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic testRegs;
        logic [31:0] a [7];
        logic [31:0] e [7];
        logic [31:0] r;
        a = '{`LPP_ADDR_DUMMY, `LPP_ADDR_MIX, `LPP_ADDR_KEYV, `LPP_ADDR_KEYM,
            `LPP_ADDR_VSTART, `LPP_ADDR_OEND, 32'hfff08100};
        e = '{32'h7fffffff, 32'h00ff037f, 32'h00ffffff, 32'h00ffffff,
            32'hffffffff, 32'hffffffff, 32'h00000000};
        busRd(`LPP_ADDR_DITH6, r);
        `CHECK_EQ(r, `LPP_RST_DITH6)
        for (int i = 0; i < 7; i++) begin
            busRd(a[i], r);
            `CHECK_EQ(r, `LPP_RST_WORD)
            busWr(a[i], 32'hffffffff);
            busRd(a[i], r);
            `CHECK_EQ(r, e[i])
            busWr(a[i], 32'h00000000);
        end
    endtask
    task automatic testLookup;
        logic [31:0] pal [4];
        pal = '{32'h5a3c1e0f, 32'h96a5c3e1, 32'h0f1e2d4b, 32'hf0e1d2b4};
        for (int k = 0; k < 4; k++) begin
            busWr(`LPP_ADDR_PAL0 + 32'(4 * k), pal[k]);
        end
        busWr(`LPP_ADDR_MODE, 32'h0);
        for (int n = 0; n < 16; n++) begin
            pix(8'(n), VC, OC, 16'd0, 16'd0);
            `CHECK_EQ(lutAddr, pal[n / 4][8 * (n % 4)+:8])
        end
        busWr(`LPP_ADDR_MODE, 32'h2);
        for (int n = 1; n < 256; n += 37) begin
            pix(8'(n), VC, OC, 16'd0, 16'd0);
            `CHECK_EQ(lutAddr, 8'(n))
        end
    endtask
    task automatic testDither;
        logic [31:0] dw [7];
        logic [15:0] h;
        dw = '{`LPP_RST_DITH0, `LPP_RST_DITH1, `LPP_RST_DITH2, 32'h0ff0a5c3,
            `LPP_RST_DITH4, `LPP_RST_DITH5, `LPP_RST_DITH6};
        busWr(`LPP_ADDR_DITH3, 32'h0ff0a5c3);
        for (int f = 0; f < 16; f++) begin
            for (int g = 0; g < 16; g++) begin
                h = (g % 2) ? dw[(g - 1) / 2][15:0] : dw[(g - 1) / 2][31:16];
                // Upper index bits set: only the low nibble is gray
                pix({4'ha, 4'(g)}, VC, OC, 16'd0, 16'd0);
                if (g == 0 || g == 15) begin
                    `CHECK_EQ(panelOn, 1'(g == 15))
                end else begin
                    `CHECK_EQ(panelOn, h[f])
                end
            end
            vsync();
        end
        pix(8'h01, VC, OC, 16'd0, 16'd0);
        `CHECK_EQ(panelOn, 1'b1)
    endtask
    task automatic testMix;
        busWr(`LPP_ADDR_VEND, 32'hffffffff);
        busWr(`LPP_ADDR_OSTART, 32'h000a000a);
        busWr(`LPP_ADDR_OEND, 32'h00140014);
        busWr(`LPP_ADDR_MODE, 32'h1);
        busWr(`LPP_ADDR_MIX, 32'h1);
        pix(8'h00, VC, OC, 16'd9, 16'd15);
        `CHECK_EQ(panelRgb, VC)
        pix(8'h00, VC, OC, 16'd15, 16'd21);
        `CHECK_EQ(panelRgb, VC)
        pix(8'h00, VC, OC, 16'd20, 16'd20);
        `CHECK_EQ(panelRgb, OC)
        pix(8'h00, VC, OC, 16'd10, 16'd10);
        `CHECK_EQ(panelRgb, OC)
        for (int c = 0; c < 4; c++) begin
            busWr(`LPP_ADDR_MIX, 32'h30 | 32'(c));
            inWin(mixExp(2'(c), 3'd3));
        end
        for (int w = 0; w < 8; w++) begin
            busWr(`LPP_ADDR_MIX, 32'(w << 4) | 32'h2);
            inWin(mixExp(2'h2, 3'(w)));
        end
        busWr(`LPP_ADDR_KEYV, {8'h00, OC ^ 24'h000001});
        busWr(`LPP_ADDR_KEYM, 32'h00000001);
        for (int c = 0; c < 4; c++) begin
            busWr(`LPP_ADDR_MIX, 32'h152 | 32'(c << 2));
            inWin(mixExp(2'(c), 3'd5));
        end
        busWr(`LPP_ADDR_MIX, 32'h004);
        inWin(VC);
        busWr(`LPP_ADDR_MIX, 32'h104);
        inWin(OC);
        busWr(`LPP_ADDR_KEYM, 32'h00000000);
        inWin(VC);
        busWr(`LPP_ADDR_KEYV, {8'h00, OC ^ 24'h800000});
        busWr(`LPP_ADDR_KEYM, 32'h00800000);
        inWin(OC);
    endtask
    task automatic testBlink;
        busWr(`LPP_ADDR_MIX, 32'h00010001);
        vsync();
        vsync();
        inWin(OC);
        busWr(`LPP_ADDR_MIX, 32'h00020201);
        for (int k = 0; k < 4; k++) begin
            inWin((k == 2 || k == 3) ? VC : OC);
            vsync();
        end
        vsync();
        vsync();
        inWin(VC);
        // Period one flips the overlay on every vertical sync
        busWr(`LPP_ADDR_MIX, 32'h00010201);
        vsync();
        inWin(OC);
        vsync();
        inWin(VC);
    endtask
    task automatic testWindow;
        logic [15:0] rows [6];
        logic [15:0] cols [6];
        rows = '{16'd5, 16'd8, 16'd4, 16'd5, 16'd9, 16'd8};
        cols = '{16'd5, 16'd8, 16'd5, 16'd4, 16'd8, 16'd9};
        busWr(`LPP_ADDR_MIX, 32'h0);
        busWr(`LPP_ADDR_VSTART, 32'h00050005);
        busWr(`LPP_ADDR_VEND, 32'h00080008);
        busWr(`LPP_ADDR_DUMMY, 32'h55a1b2c3);
        for (int i = 0; i < 6; i++) begin
            pix(8'h00, VC, OC, rows[i], cols[i]);
            if (i < 2) begin
                `CHECK_EQ(panelRgb, VC)
            end else if (i < 4) begin
                `CHECK_EQ(panelRgb, 24'ha1b2c3)
            end else begin
                `CHECK_EQ(panelRgb, 24'ha1b2c3)
            end
        end
        // Gray 7'h55 fills the low bits of raw 8'hb6
        busWr(`LPP_ADDR_MODE, 32'h2);
        pix(8'hb6, VC, OC, 16'd6, 16'd6);
        `CHECK_EQ(panelRgb, 24'hb5b5aa)
        busWr(`LPP_ADDR_MODE, 32'h3);
        pix(8'hb6, VC, OC, 16'd6, 16'd6);
        `CHECK_EQ(panelRgb, VC)
    endtask

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        // Whole run is about 1250 cycles; this is far past it
        #200000;
        numErrors++;
        summarize();
    end
    initial begin
        ref_clk = 1'b0;
        nrst = 1'b0;
        {hsel, hwrite, pixValid, vsyncPulse} = 4'h0;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        hsize = `LPP_HSIZE_WORD;
        pixIndex = 8'h00;
        {lutRgb, osdRgb} = 48'h0;
        {pixRow, pixCol} = 32'h0;
        numErrors = 0;
        testsRun = 0;
        pixSent = 0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        testRegs();
        testLookup();
        testDither();
        testMix();
        testBlink();
        testWindow();
        `CHECK_EQ(panelCount, pixSent)
        summarize();
    end
endmodule // lpp_post_tb
`default_nettype wire
